// ===== logic/stepper_pkg.sv
package stepper_pkg;
   // register indices on the register-communication port
   localparam logic [5:0] REG_TARGET_LOW = 6'h02;
   localparam logic [5:0] REG_TARGET_HIGH = 6'h03;
   localparam logic [5:0] REG_LATCH_HIGH = 6'h05;
   localparam logic [5:0] REG_FEATURE = 6'h20;
   localparam logic [5:0] REG_FULL_STEPS = 6'h21;
   localparam logic [5:0] REG_LATCH_COUNT = 6'h25;
   localparam logic [5:0] REG_AUTO_HOLD = 6'h2c;
   localparam logic [5:0] REG_MANUAL_HOLD = 6'h2d;
   localparam logic [5:0] REG_STEP_RES = 6'h2e;
   localparam logic [5:0] REG_SENSOR_PPR = 6'h33;
   localparam logic [5:0] REG_FEATURE_TWO = 6'h34;
   // reset values
   localparam logic [15:0] FEATURE_RST = 16'h0000;
   localparam logic [15:0] FULL_STEPS_RST = 16'h00c8;
   localparam logic [15:0] LATCH_COUNT_RST = 16'h0001;
   localparam logic [15:0] AUTO_HOLD_RST = 16'h0032;
   localparam logic [15:0] MANUAL_HOLD_RST = 16'h0032;
   localparam logic [15:0] STEP_RES_RST = 16'h0006;
   localparam logic [15:0] SENSOR_PPR_RST = 16'h0008;
   localparam logic [15:0] FEATURE_TWO_RST = 16'h0000;
   // control word bits
   localparam int CW_ARM_INDEX = 0;
   localparam int CW_ARM_IN1 = 1;
   localparam int CW_ARM_IN2 = 2;
   localparam int CW_ARM_GATE_RISE = 3;
   localparam int CW_ARM_GATE_FALL = 4;
   localparam int CW_READOUT = 5;
   localparam int CW_NEXT_TOGGLE = 6;
   localparam int CW_ERROR_VIEW = 7;
   localparam int CW_MIXED_DECAY_OFF = 9;
   localparam int CW_TARGET_LOAD = 10;
   localparam int CW_MANUAL_HOLD = 11;
   localparam int CW_TARGET_CLEAR = 13;
   // control byte bits
   localparam int CB_MANUAL_HOLD = 3;
   localparam int CB_FAULT_CLEAR = 6;
   // feature bits
   localparam int FT_CUSTOM_TABLE = 7;
   localparam int FT_LATCH_CLEARS = 8;
   localparam int FT_LATCH_ARRAY = 9;
   localparam int FT2_IN1_NC = 14;
   localparam int FT2_IN2_NC = 15;
   // thresholds and sizes
   localparam logic [7:0] TEMP_WARN_SET = 8'd80;
   localparam logic [7:0] TEMP_WARN_CLEAR = 8'd60;
   localparam logic [7:0] FULL_CURRENT_PCT = 8'd100;
   localparam logic [4:0] STEP_RES_MAX = 5'd6;
   localparam int LATCH_DEPTH = 8;
   localparam int FAULT_COUNT = 7;
endpackage

// ===== logic/stepper_latch_position_status.sv
// Behaviour
// - load angle shown in status byte bits 1..3, refreshed after each full step
// - control word bit 9 set turns mixed decay off, otherwise it stays on
// - feature bit 7 selects the user current table instead of the sine table
// - at zero velocity apply automatic hold percentage of configured coil current
// - control byte bit 3 or control word bit 11 forces manual hold current
// - rising edge of control word bit 13 clears target; beats a load request
// - rising edge of control word bit 10 loads target from two registers, acked bit 2
// - path control takes a 32-bit target and travels to it once enabled
// - count input 2 pulses; factor = microsteps times full steps over pulses
// - position error = position minus tally times factor, shown on control bit 7
// - encoder decoded fourfold, every edge of both tracks counted
// - latch sources armed by control bits 0,3,4,1,2 in that priority
// - one latch value by default; feature bit 9 stores up to programmed count
// - feature bit 8, armed source and bit 13 clear position at next latch
// - latch captures position and sets status bit 4, in array mode after count
// - control bit 5 shows latch low word, ack bit 5, high word in register 5
// - toggling control bit 6 advances latch readout, echoed on status bit 6
// - withdrawing latch enable discards all stored latch values
// - feature-two bits 14 and 15 make inputs 1 and 2 normally closed
// - status bit 15 flags zero or out-of-range parameters, clears itself
// - thermal warning sets at 80 degrees, clears below 60 degrees
// - hardware faults cut motor power, set status byte bit 6 and word bits 8..14
// - control byte bit 6 clears the hardware fault flag
`timescale 1ns/100ps
module stepper_latch_position_status (
   input wire logic clk_sys, // system clock, 250 MHz
   input wire logic rst, // asynchronous reset, active high
   input wire logic [15:0] control_word, // cyclic control word
   input wire logic [7:0] control_byte, // cyclic control byte
   output logic [15:0] status_word, // cyclic status word
   output logic [7:0] status_byte, // cyclic status byte
   output logic [15:0] input_process_word, // cyclic input data word
   input wire logic [5:0] reg_addr, // register index
   input wire logic reg_wr, // register write strobe
   input wire logic [15:0] reg_wdata, // register write data
   output logic [15:0] reg_rdata, // register read data, one cycle after address
   input wire logic signed [15:0] commanded_velocity, // velocity from the ramp logic
   input wire logic [31:0] commanded_position, // set position in microsteps
   input wire logic full_step_done, // pulse per completed full step
   input wire logic [2:0] load_angle_meas, // measured load angle
   input wire logic [7:0] coil_current_setting, // configured coil current
   input wire logic [7:0] temperature, // housing temperature, degrees
   input wire logic path_param_error, // derived path parameters out of range
   input wire logic path_enable, // path control start enable
   input wire logic enc_a, // encoder track A pin
   input wire logic enc_b, // encoder track B pin
   input wire logic enc_index, // encoder index pin
   input wire logic latch_gate, // latch/gate pin
   input wire logic din1, // digital input 1 pin
   input wire logic din2, // digital input 2 pin
   input wire logic [stepper_pkg::FAULT_COUNT-1:0] fault_pins, // overheat..supply lost
   output logic mixed_decay_on, // mixed decay pulsing active
   output logic custom_table_select, // use user current table
   output logic [7:0] coil_current_cmd, // coil current after hold reduction
   output logic motor_power_enable, // bridge power allowed
   output logic [31:0] target_position, // stored target position
   output logic path_run, // travel to target requested
   output logic [31:0] encoder_position // fourfold encoder count
);
   import stepper_pkg::*;

   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);

   logic [15:0] target_low_r, target_high_r, feature_r, full_steps_r, latch_count_r;
   logic [15:0] auto_hold_r, manual_hold_r, step_res_r, sensor_ppr_r, feature_two_r;
   logic [12:0] pin_s1_r, pin_s2_r, pin_prev_r;
   logic [15:0] cw_prev_r;
   logic a_now, b_now, a_old, b_old, idx_now, idx_old, gate_now, gate_old;
   logic in1_now, in1_old, in2_now, in2_old;
   logic [FAULT_COUNT-1:0] fault_now;
   logic [31:0] target_r, enc_pos_r, pos_err_r;
   logic ack_r, captured_r, echo_r, warn_r, hw_fault_r;
   logic [FAULT_COUNT-1:0] fault_flags_r;
   logic [2:0] load_angle_r;
   logic [7:0] current_cmd_r;
   logic [15:0] tally_r;
   logic [21:0] pulse_factor_r;
   logic [31:0] latch_mem_r [LATCH_DEPTH];
   logic [3:0] latch_fill_r, rd_idx_r;
   logic [15:0] event_cnt_r;
   logic [15:0] ipw_r, rdata_r;
   logic path_run_r, clear_armed_r;
   logic load_rise, clear_rise, toggle_change, latch_enable, latch_event, config_fault;
   logic [4:0] arm_hits;
   logic [3:0] latch_limit;
   logic [21:0] pf_num;
   logic [37:0] err_product;
   logic [7:0] hold_pct;
   logic [15:0] scaled_current;

   // two-stage synchronisers for every pin; stage one feeds only stage two
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pin_s1_r <= 13'h0000;
         pin_s2_r <= 13'h0000;
         pin_prev_r <= 13'h0000;
      end else begin
         pin_s1_r <= {fault_pins, din2, din1, latch_gate, enc_index, enc_b, enc_a};
         pin_s2_r <= pin_s1_r;
         pin_prev_r <= pin_s2_r;
      end
   end

   assign a_now = pin_s2_r[0];
   assign a_old = pin_prev_r[0];
   assign b_now = pin_s2_r[1];
   assign b_old = pin_prev_r[1];
   assign idx_now = pin_s2_r[2];
   assign idx_old = pin_prev_r[2];
   assign gate_now = pin_s2_r[3];
   assign gate_old = pin_prev_r[3];
   assign in1_now = pin_s2_r[4] ^ feature_two_r[FT2_IN1_NC];
   assign in1_old = pin_prev_r[4] ^ feature_two_r[FT2_IN1_NC];
   assign in2_now = pin_s2_r[5] ^ feature_two_r[FT2_IN2_NC];
   assign in2_old = pin_prev_r[5] ^ feature_two_r[FT2_IN2_NC];
   assign fault_now = pin_s2_r[12:6];

   // register file; latch high word is read only
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         target_low_r <= 16'h0000;
         target_high_r <= 16'h0000;
         feature_r <= FEATURE_RST;
         full_steps_r <= FULL_STEPS_RST;
         latch_count_r <= LATCH_COUNT_RST;
         auto_hold_r <= AUTO_HOLD_RST;
         manual_hold_r <= MANUAL_HOLD_RST;
         step_res_r <= STEP_RES_RST;
         sensor_ppr_r <= SENSOR_PPR_RST;
         feature_two_r <= FEATURE_TWO_RST;
      end else if (reg_wr) begin
         case (reg_addr)
            REG_TARGET_LOW: target_low_r <= reg_wdata;
            REG_TARGET_HIGH: target_high_r <= reg_wdata;
            REG_FEATURE: feature_r <= reg_wdata;
            REG_FULL_STEPS: full_steps_r <= reg_wdata;
            REG_LATCH_COUNT: latch_count_r <= reg_wdata;
            REG_AUTO_HOLD: auto_hold_r <= reg_wdata;
            REG_MANUAL_HOLD: manual_hold_r <= reg_wdata;
            REG_STEP_RES: step_res_r <= reg_wdata;
            REG_SENSOR_PPR: sensor_ppr_r <= reg_wdata;
            REG_FEATURE_TWO: feature_two_r <= reg_wdata;
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rdata_r <= 16'h0000;
      end else begin
         case (reg_addr)
            REG_TARGET_LOW: rdata_r <= target_low_r;
            REG_TARGET_HIGH: rdata_r <= target_high_r;
            REG_LATCH_HIGH: rdata_r <= latch_mem_r[rd_idx_r[2:0]][31:16];
            REG_FEATURE: rdata_r <= feature_r;
            REG_FULL_STEPS: rdata_r <= full_steps_r;
            REG_LATCH_COUNT: rdata_r <= latch_count_r;
            REG_AUTO_HOLD: rdata_r <= auto_hold_r;
            REG_MANUAL_HOLD: rdata_r <= manual_hold_r;
            REG_STEP_RES: rdata_r <= step_res_r;
            REG_SENSOR_PPR: rdata_r <= sensor_ppr_r;
            REG_FEATURE_TWO: rdata_r <= feature_two_r;
            default: rdata_r <= 16'h0000;
         endcase
      end
   end
   assign reg_rdata = rdata_r;

   // control edges
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cw_prev_r <= 16'h0000;
      end else begin
         cw_prev_r <= control_word;
      end
   end
   assign clear_rise = control_word[CW_TARGET_CLEAR] & ~cw_prev_r[CW_TARGET_CLEAR];
   assign load_rise = control_word[CW_TARGET_LOAD] & ~cw_prev_r[CW_TARGET_LOAD];
   assign toggle_change = control_word[CW_NEXT_TOGGLE] ^ cw_prev_r[CW_NEXT_TOGGLE];

   // target position; ack stays until both requests are released, a new edge wins
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         target_r <= 32'h0000_0000;
         ack_r <= 1'b0;
      end else begin
         if (clear_rise) begin
            target_r <= 32'h0000_0000;
         end else if (load_rise) begin
            target_r <= {target_high_r, target_low_r};
         end
         if (clear_rise || load_rise) begin
            ack_r <= 1'b1;
         end else if (!control_word[CW_TARGET_CLEAR] && !control_word[CW_TARGET_LOAD]) begin
            ack_r <= 1'b0;
         end
      end
   end
   assign target_position = target_r;

   // configuration check: zero registers or derived values out of range
   assign config_fault = (full_steps_r == 16'h0000) || (sensor_ppr_r == 16'h0000) ||
                         (step_res_r > {11'h000, STEP_RES_MAX}) || path_param_error;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         path_run_r <= 1'b0;
      end else begin
         path_run_r <= path_enable && !config_fault && !hw_fault_r &&
                       (commanded_position != target_r);
      end
   end
   assign path_run = path_run_r;

   // current shaping
   assign hold_pct = (control_byte[CB_MANUAL_HOLD] || control_word[CW_MANUAL_HOLD]) ? manual_hold_r[7:0] :
                     (commanded_velocity == 16'sh0000) ? auto_hold_r[7:0] : FULL_CURRENT_PCT;
   // scaled against the configured coil current, not the rated one
   assign scaled_current = (16'(coil_current_setting) * 16'(hold_pct)) / 16'(FULL_CURRENT_PCT);

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         current_cmd_r <= 8'h00;
         mixed_decay_on <= 1'b1;
         custom_table_select <= 1'b0;
      end else begin
         current_cmd_r <= (scaled_current > 16'h00ff) ? 8'hff : scaled_current[7:0];
         mixed_decay_on <= ~control_word[CW_MIXED_DECAY_OFF];
         custom_table_select <= feature_r[FT_CUSTOM_TABLE];
      end
   end
   assign coil_current_cmd = current_cmd_r;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         load_angle_r <= 3'h0;
      end else if (full_step_done) begin
         load_angle_r <= load_angle_meas;
      end
   end

   // sensor tally and position error; the divider is combinational and settles in one cycle
   assign pf_num = 22'(full_steps_r) << step_res_r[2:0];
   assign err_product = 38'(tally_r) * 38'(pulse_factor_r);
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         tally_r <= 16'h0000;
         pulse_factor_r <= 22'h000000;
         pos_err_r <= 32'h0000_0000;
      end else begin
         if (in2_now && !in2_old) begin
            tally_r <= tally_r + 16'h0001;
         end
         pulse_factor_r <= (sensor_ppr_r == 16'h0000) ? 22'h000000 : pf_num / 22'(sensor_ppr_r);
         pos_err_r <= commanded_position - err_product[31:0];
      end
   end

   // latch sources in priority order: index, gate rise, gate fall, input 1, input 2
   assign arm_hits = {control_word[CW_ARM_INDEX] & idx_now & ~idx_old,
                      control_word[CW_ARM_GATE_RISE] & gate_now & ~gate_old,
                      control_word[CW_ARM_GATE_FALL] & ~gate_now & gate_old,
                      control_word[CW_ARM_IN1] & in1_now & ~in1_old,
                      control_word[CW_ARM_IN2] & in2_now & ~in2_old};
   assign latch_enable = control_word[CW_ARM_INDEX] | control_word[CW_ARM_GATE_RISE] |
                         control_word[CW_ARM_GATE_FALL] | control_word[CW_ARM_IN1] |
                         control_word[CW_ARM_IN2];
   assign latch_event = |arm_hits;
   assign latch_limit = !feature_r[FT_LATCH_ARRAY] ? 4'd1 :
                        (latch_count_r == 16'h0000) ? 4'd1 :
                        (latch_count_r > 16'(LATCH_DEPTH)) ? 4'(LATCH_DEPTH) : latch_count_r[3:0];

   // fourfold decode plus latch-driven position clear
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         enc_pos_r <= 32'h0000_0000;
         clear_armed_r <= 1'b0;
      end else begin
         if (!latch_enable || !feature_r[FT_LATCH_CLEARS]) begin
            clear_armed_r <= 1'b0;
         end else if (control_word[CW_TARGET_CLEAR]) begin
            clear_armed_r <= 1'b1;
         end
         if (latch_event && clear_armed_r) begin
            enc_pos_r <= 32'h0000_0000;
            clear_armed_r <= 1'b0;
         end else if ((a_now ^ a_old) || (b_now ^ b_old)) begin
            if (a_old ^ b_now) begin
               enc_pos_r <= enc_pos_r + 32'h0000_0001;
            end else begin
               enc_pos_r <= enc_pos_r - 32'h0000_0001;
            end
         end
      end
   end
   assign encoder_position = enc_pos_r;

   // latch storage and toggle readout
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < LATCH_DEPTH; i++) begin
            latch_mem_r[i] <= 32'h0000_0000;
         end
         latch_fill_r <= 4'h0;
         event_cnt_r <= 16'h0000;
         captured_r <= 1'b0;
         rd_idx_r <= 4'h0;
         echo_r <= 1'b0;
      end else if (!latch_enable) begin
         latch_fill_r <= 4'h0;
         event_cnt_r <= 16'h0000;
         captured_r <= 1'b0;
         rd_idx_r <= 4'h0;
         echo_r <= control_word[CW_NEXT_TOGGLE];
      end else begin
         if (latch_event && latch_fill_r < latch_limit) begin
            latch_mem_r[latch_fill_r[2:0]] <= enc_pos_r;
            latch_fill_r <= latch_fill_r + 4'h1;
            event_cnt_r <= event_cnt_r + 16'h0001;
            if (latch_fill_r + 4'h1 == latch_limit) begin
               captured_r <= 1'b1;
            end
         end
         // an unanswered toggle marks the last stored value
         if (control_word[CW_READOUT] && toggle_change && rd_idx_r + 4'h1 < latch_fill_r) begin
            rd_idx_r <= rd_idx_r + 4'h1;
            echo_r <= control_word[CW_NEXT_TOGGLE];
         end
      end
   end

   // faults and warnings; the fault set wins over the clear
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         warn_r <= 1'b0;
         hw_fault_r <= 1'b0;
         fault_flags_r <= '0;
      end else begin
         if (temperature >= TEMP_WARN_SET) begin
            warn_r <= 1'b1;
         end else if (temperature < TEMP_WARN_CLEAR) begin
            warn_r <= 1'b0;
         end
         if (|fault_now) begin
            hw_fault_r <= 1'b1;
            fault_flags_r <= fault_flags_r | fault_now;
         end else if (control_byte[CB_FAULT_CLEAR]) begin
            hw_fault_r <= 1'b0;
            fault_flags_r <= '0;
         end
      end
   end
   assign motor_power_enable = ~hw_fault_r & ~(|fault_now);

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ipw_r <= 16'h0000;
      end else if (control_word[CW_READOUT] && latch_enable) begin
         ipw_r <= latch_mem_r[rd_idx_r[2:0]][15:0];
      end else if (control_word[CW_ERROR_VIEW]) begin
         ipw_r <= pos_err_r[15:0];
      end else begin
         ipw_r <= enc_pos_r[15:0];
      end
   end
   assign input_process_word = ipw_r;

   assign status_word = {config_fault, fault_flags_r, 1'b0, echo_r,
                         control_word[CW_READOUT] & latch_enable, captured_r, 1'b0, ack_r, 2'b00};
   assign status_byte = {1'b0, hw_fault_r, warn_r, 1'b0, load_angle_r, 1'b0};

   a_target_clear_wins: assert property (clear_rise |=> target_r == 32'h0000_0000 && ack_r)
      else $error("target not cleared on clear edge");
   a_target_load: assert property (load_rise && !clear_rise |=> target_r == $past({target_high_r, target_low_r}))
      else $error("target not loaded from registers");
   a_load_angle_hold: assert property (!full_step_done |=> $stable(load_angle_r))
      else $error("load angle changed without full step");
   a_mixed_decay_follow: assert property (control_word[CW_MIXED_DECAY_OFF] |=> !mixed_decay_on)
      else $error("mixed decay still on");
   a_fault_cuts_power: assert property ($rose(|fault_now) |-> !motor_power_enable ##1 hw_fault_r)
      else $error("fault did not cut power");
   a_fault_clear: assert property (hw_fault_r && control_byte[CB_FAULT_CLEAR] && !(|fault_now) |=> !hw_fault_r)
      else $error("fault flag not cleared");
   a_warn_hyst: assert property (temperature >= TEMP_WARN_SET |=> warn_r ##1 (warn_r || $past(temperature) < TEMP_WARN_CLEAR))
      else $error("thermal warning wrong");
   a_latch_discard: assert property (!latch_enable |=> latch_fill_r == 4'h0 && !captured_r)
      else $error("latch values kept after enable dropped");
   a_single_latch: assert property (!feature_r[FT_LATCH_ARRAY] |-> latch_fill_r <= 4'd1)
      else $error("more than one latch value by default");
   a_echo_on_toggle: assert property ($changed(echo_r) && latch_enable && $past(latch_enable) |-> $past(toggle_change))
      else $error("echo without toggle");
   a_manual_hold: assert property (control_byte[CB_MANUAL_HOLD] |-> hold_pct == manual_hold_r[7:0])
      else $error("manual hold not applied");

   c_latch_capture: cover property (latch_event ##[1:20] captured_r);
   c_readout_advance: cover property (control_word[CW_READOUT] ##1 $changed(echo_r));
   c_fault_cycle: cover property (hw_fault_r ##[1:10] !hw_fault_r);
endmodule

// ===== bench/plc_model.sv
`timescale 1ns/100ps
module plc_model (
   input wire logic clk_sys, // system clock
   input wire logic [15:0] cw_req, // word the program wants sent
   input wire logic [7:0] cb_req, // byte the program wants sent
   output logic [15:0] control_word = 16'h0000, // cyclic control word
   output logic [7:0] control_byte = 8'h00 // cyclic control byte
);
   // one cyclic exchange per falling edge, so a request is seen a cycle late
   always @(negedge clk_sys) begin
      control_word <= cw_req;
      control_byte <= cb_req;
   end
endmodule

// ===== bench/tb_stepper_latch_position_status.sv
`timescale 1ns/100ps
module tb_stepper_latch_position_status;
   import stepper_pkg::*;
   logic clk_sys = 1'b0, rst = 1'b1, reg_wr = 1'b0, full_step_done = 1'b0, enc_a = 1'b0, enc_b = 1'b0;
   logic din2 = 1'b0, path_param_error = 1'b0, mixed_decay_on, custom_table_select, motor_power_enable, path_run;
   logic [15:0] cw_req = 16'h0000, reg_wdata = 16'h0000, control_word, status_word, input_process_word, reg_rdata;
   logic [7:0] cb_req = 8'h00, temperature = 8'h14, coil_current_setting = 8'hc8, control_byte, status_byte;
   logic [7:0] coil_current_cmd;
   logic [5:0] reg_addr = 6'h00;
   logic signed [15:0] commanded_velocity = 16'sh0000;
   logic [2:0] load_angle_meas = 3'h0;
   logic [6:0] fault_pins = 7'h00;
   logic [31:0] target_position, encoder_position, commanded_position = 32'h0000_0000;
   logic path_enable = 1'b0, din1 = 1'b0, latch_gate = 1'b0;
   int error_cnt = 0, checks = 0, cycles = 0;
   plc_model partner (.clk_sys, .cw_req, .cb_req, .control_word, .control_byte);
   stepper_latch_position_status dut (.clk_sys, .rst, .control_word, .control_byte, .status_word, .status_byte,
      .input_process_word, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .commanded_velocity,
      .commanded_position, .full_step_done, .load_angle_meas, .coil_current_setting, .temperature,
      .path_param_error, .path_enable, .enc_a, .enc_b, .enc_index(1'b0), .latch_gate, .din1,
      .din2, .fault_pins, .mixed_decay_on, .custom_table_select, .coil_current_cmd, .motor_power_enable,
      .target_position, .path_run, .encoder_position);
   initial forever #2 clk_sys = ~clk_sys;
   task automatic step(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      step(1);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      step(1);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [5:0] a, input logic [15:0] exp);
      step(1);
      reg_addr <= a;
      step(2);
      chk("reg_rdata", exp, reg_rdata);
   endtask
   task automatic cw(input logic [15:0] w, input int n);
      cw_req <= w;
      step(n);
   endtask
   task automatic t_regs;
      rd(REG_FULL_STEPS, FULL_STEPS_RST);
      rd(REG_LATCH_COUNT, LATCH_COUNT_RST);
      wr(REG_LATCH_HIGH, 16'hbeef);
      rd(REG_LATCH_HIGH, 16'h0000);
      rd(6'h3f, 16'h0000);
   endtask
   task automatic t_target;
      wr(REG_TARGET_LOW, 16'h1234);
      wr(REG_TARGET_HIGH, 16'habcd);
      cw(16'h0400, 3);
      chk("target", 32'habcd1234, target_position);
      chk("ack", 1'b1, status_word[2]);
      path_enable <= 1'b1;
      step(2);
      chk("path_run", 1'b1, path_run);
      commanded_position <= 32'habcd1234;
      step(2);
      chk("path_run", 1'b0, path_run);
      path_enable <= 1'b0;
      cw(16'h0000, 3);
      cw(16'h2400, 3);
      chk("target", 32'h0, target_position);
      cw(16'h0200, 3);
      chk("decay", 1'b0, mixed_decay_on);
   endtask
   task automatic t_drive;
      wr(REG_FEATURE, 16'h0080);
      wr(REG_MANUAL_HOLD, 16'h0019);
      load_angle_meas <= 3'h5;
      full_step_done <= 1'b1;
      step(1);
      full_step_done <= 1'b0;
      step(2);
      chk("angle", 3'h5, status_byte[3:1]);
      chk("table", 1'b1, custom_table_select);
      chk("auto", 8'd100, coil_current_cmd);
      cb_req <= 8'h08;
      commanded_velocity <= 16'sh0040;
      step(3);
      chk("manual", 8'd50, coil_current_cmd);
      cb_req <= 8'h00;
      step(3);
      chk("run", 8'd200, coil_current_cmd);
   endtask
   task automatic t_flags;
      temperature <= 8'd80;
      path_param_error <= 1'b1;
      step(2);
      chk("warn", 1'b1, status_byte[5]);
      chk("cfg", 1'b1, status_word[15]);
      temperature <= 8'd60;
      path_param_error <= 1'b0;
      step(2);
      chk("warn", 1'b1, status_byte[5]);
      chk("cfg", 2'b00, {status_word[15], status_byte[6]});
      temperature <= 8'd59;
      fault_pins <= 7'h04;
      step(4);
      chk("warn", 1'b0, status_byte[5]);
      chk("fault", 3'b110, {status_word[10], status_byte[6], motor_power_enable});
      fault_pins <= 7'h00;
      cb_req <= 8'h40;
      step(4);
      chk("clear", 1'b0, status_byte[6]);
      cb_req <= 8'h00;
   endtask
   task automatic t_latch;
      enc_a <= 1'b1;
      step(2);
      enc_b <= 1'b1;
      step(2);
      enc_a <= 1'b0;
      step(2);
      enc_b <= 1'b0;
      step(5);
      chk("enc", 32'd4, encoder_position[31] ? -encoder_position : encoder_position);
      cw(16'h0004, 3);
      din2 <= 1'b1;
      step(5);
      chk("capt", 1'b1, status_word[4]);
      cw(16'h0024, 3);
      chk("rdack", 1'b1, status_word[5]);
      chk("low", 16'd4, 16'(input_process_word[15] ? -input_process_word : input_process_word));
      cw(16'h0000, 3);
      chk("drop", 2'b00, status_word[5:4]);
      // input 1 as normally closed: a falling pin edge is a rising input edge
      wr(REG_FEATURE_TWO, 16'h4000);
      wr(REG_FEATURE, 16'h0280);
      wr(REG_LATCH_COUNT, 16'h0002);
      cw(16'h0002, 3);
      din1 <= 1'b1;
      step(4);
      din1 <= 1'b0;
      step(5);
      chk("capt1", 1'b0, status_word[4]);
      din1 <= 1'b1;
      step(4);
      din1 <= 1'b0;
      step(5);
      chk("capt2", 1'b1, status_word[4]);
      cw(16'h0062, 3);
      chk("echo", 1'b1, status_word[6]);
      cw(16'h0022, 3);
      chk("last", 1'b1, status_word[6]);
      wr(REG_FEATURE, 16'h0380);
      cw(16'h2008, 3);
      latch_gate <= 1'b1;
      step(5);
      chk("zero", 32'h0, encoder_position);
      // factor 64 microsteps times 200 steps over 8 pulses, one pulse counted
      cw(16'h0080, 3);
      chk("err", 16'(32'habcd1234 - 32'd1600), input_process_word);
   endtask
   task automatic wrap_up;
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      // generous: the sequence needs about 133 cycles
      if (cycles == 5000) begin
         error_cnt++;
         wrap_up;
      end
   end
   initial begin
      step(3);
      rst <= 1'b0;
      t_regs;
      t_target;
      t_drive;
      t_flags;
      t_latch;
      wrap_up;
   end
endmodule
